// >>> logic/hbridge_ctrl_regs.svh
// Offsets, field positions, reset values and timing counts of the control register bank
`ifndef HBRIDGE_CTRL_REGS_SVH
`define HBRIDGE_CTRL_REGS_SVH

// ==========================================================================
// Register offsets and reset values
`define MAIN_CONTROL_OFS 4'h2
`define GATE_WD_CONTROL_OFS 4'h3
`define OVERCURRENT_CONTROL_OFS 4'h4
`define CONFIG_CONTROL_OFS 4'h5
`define MAIN_CONTROL_RST 8'h18
`define GATE_WD_CONTROL_RST 8'h07
`define OVERCURRENT_CONTROL_RST 8'h70
`define CONFIG_CONTROL_RST 8'h01

// ==========================================================================
// Serial word layout and bit counts
`define WORD_READ_BIT 15
`define WORD_ADDR_MSB 14
`define WORD_ADDR_LSB 11
`define WORD_LAST_EDGE 5'h0f
`define WORD_OVER_EDGE 5'h10
`define WORD_CNT_SAT 5'h11
`define WORD_ADDR_DONE 5'h07
`define WORD_DATA_FIRST 5'h08

// ==========================================================================
// Field positions
`define LOCK_MSB 5
`define LOCK_LSB 3
`define LOCK_KEY 3'h6
`define UNLOCK_KEY 3'h3
`define BRIDGE_FIRST_BIT 2
`define BRIDGE_SECOND_BIT 1
`define FAULT_CLEAR_BIT 0
`define DEAD_TIME_MSB 7
`define DEAD_TIME_LSB 6
`define WD_ENABLE_BIT 5
`define WD_SEL_MSB 4
`define WD_SEL_LSB 3
`define GATE_CODE_MSB 2
`define GATE_CODE_LSB 0
`define AMP_LIMIT_BIT 7
`define OC_THR_MSB 6
`define OC_THR_LSB 4
`define B2_HIGH_OFF_BIT 3
`define B2_LOW_OFF_BIT 2
`define B1_HIGH_OFF_BIT 1
`define B1_LOW_OFF_BIT 0

// ==========================================================================
// Timing
`define SYS_CLK_PERIOD_PS 5000
`define DEAD_TIME_BASE_NS 120
`define DEAD_TIME_BASE_CYC ((`DEAD_TIME_BASE_NS * 1000 + `SYS_CLK_PERIOD_PS - 1) / `SYS_CLK_PERIOD_PS)
`define CYC_PER_MS (1000000000 / `SYS_CLK_PERIOD_PS)
`define WD_TIMEOUT0_MS 10
`define WD_TIMEOUT1_MS 20
`define WD_TIMEOUT2_MS 50
`define WD_TIMEOUT3_MS 100

`endif

// >>> logic/hbridge_ctrl_pkg.sv
// Types shared by the control register bank
package hbridge_ctrl_pkg;
  typedef enum logic [1:0] {
    LOCK_OPEN = 2'b01,
    LOCK_SHUT = 2'b10
  } lock_state_type;
  typedef logic [7:0] reg_byte_type;
  typedef logic [3:0] reg_addr_type;
  typedef logic [24:0] wd_count_type;
endpackage

// >>> logic/hbridge_driver_control_regs.sv
// Control register bank of the H-bridge gate driver with its serial port
//
// Overview of operation
// [R1] Key 110b locks; locked ignores non-main writes
// [R2] Other keys while unlocked leave lock unchanged
// [R3] Key 011b unlocks; lock field resets 011b
// [R4] Other keys while locked keep it locked
// [R5] First bridge input is bit2 OR pin
// [R6] Second bridge input is bit1 OR pin
// [R7] Writing one to bit0 clears fault bits
// [R8] Fault-clear bit returns to zero afterwards
// [R9] Dead time 120/240/480/960 ns, reset 00b
// [R10] Watchdog runs only while enable bit set
// [R11] Watchdog timeout 10/20/50/100 ms select
// [R12] Gate current code bits 2-0, reset 111b
// [R13] Bit7 limits amplifier output, reset 0b
// [R14] Overcurrent threshold code bits 6-4, reset 111b
// [R15] Per-FET monitor disable bits 3-0, reset 0
// [R16] Host leaves reserved offsets untouched
// [R17] Control registers read back their contents
// [R18] Word: R/W bit15, address 14-11, data 7-0
`timescale 1ns/1ps
`include "hbridge_ctrl_regs.svh"
module hbridge_driver_control_regs
  import hbridge_ctrl_pkg::*;
#(
  parameter wd_count_type WD_CYC_SEL0 = 25'(`WD_TIMEOUT0_MS * `CYC_PER_MS),
  parameter wd_count_type WD_CYC_SEL1 = 25'(`WD_TIMEOUT1_MS * `CYC_PER_MS),
  parameter wd_count_type WD_CYC_SEL2 = 25'(`WD_TIMEOUT2_MS * `CYC_PER_MS),
  parameter wd_count_type WD_CYC_SEL3 = 25'(`WD_TIMEOUT3_MS * `CYC_PER_MS)
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_SPI_SCLK,
  input wire logic I_SPI_CS_N,
  input wire logic I_SPI_SDI,
  input wire logic I_BRIDGE_INPUT_FIRST,
  input wire logic I_BRIDGE_INPUT_SECOND,
  output logic O_SPI_SDO,
  output logic O_SPI_SDO_OE,
  output logic O_BRIDGE_INPUT_FIRST,
  output logic O_BRIDGE_INPUT_SECOND,
  output logic O_FAULT_CLEAR,
  output logic O_LOCKED,
  output logic [1:0] O_DEAD_TIME_SELECT,
  output logic [7:0] O_DEAD_TIME_CYCLES,
  output logic O_WATCHDOG_ENABLE,
  output logic [1:0] O_WATCHDOG_TIMEOUT_SELECT,
  output logic O_WATCHDOG_EXPIRED,
  output logic [2:0] O_GATE_CURRENT_CODE,
  output logic O_AMP_OUTPUT_LIMIT,
  output logic [2:0] O_OVERCURRENT_THRESHOLD_CODE,
  output logic O_BRIDGE2_HIGH_MONITOR_OFF,
  output logic O_BRIDGE2_LOW_MONITOR_OFF,
  output logic O_BRIDGE1_HIGH_MONITOR_OFF,
  output logic O_BRIDGE1_LOW_MONITOR_OFF,
  output logic [7:0] O_CONFIGURATION_CONTROL
);

  // ========================================================================
  // Functions
  function automatic reg_byte_type reg_read(input reg_addr_type a, input reg_byte_type m,
                                            input reg_byte_type g, input reg_byte_type o,
                                            input reg_byte_type c);
    unique case (a)
      `MAIN_CONTROL_OFS: reg_read = m;
      `GATE_WD_CONTROL_OFS: reg_read = g;
      `OVERCURRENT_CONTROL_OFS: reg_read = o;
      `CONFIG_CONTROL_OFS: reg_read = c;
      default: reg_read = 8'h00;
    endcase
  endfunction

  function automatic wd_count_type wd_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0: wd_limit = WD_CYC_SEL0;
      2'h1: wd_limit = WD_CYC_SEL1;
      2'h2: wd_limit = WD_CYC_SEL2;
      2'h3: wd_limit = WD_CYC_SEL3;
    endcase
  endfunction

  function automatic logic [7:0] dead_cycles(input logic [1:0] sel);
    dead_cycles = 8'(`DEAD_TIME_BASE_CYC) << sel;
  endfunction

  reg_byte_type main_ff, gdw_ff, ocm_ff, cfg_ff;
  lock_state_type lock_ff;

  // ========================================================================
  // Link side: bit counter, shift register and read data, cleared while deselected
  logic frame_idle;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [14:0] sh_ff, nxt_sh;
  reg_byte_type rdata_ff, nxt_rdata;

  assign frame_idle = I_SPI_CS_N | ~I_RSTN;

  // Registers only change at frame end, so the bank is steady while a frame shifts
  always_comb begin
    nxt_cnt = (cnt_ff == `WORD_CNT_SAT) ? cnt_ff : cnt_ff + 5'h01;
    nxt_sh = {sh_ff[13:0], I_SPI_SDI};
    nxt_rdata = rdata_ff;
    if (cnt_ff == `WORD_ADDR_DONE) begin
      nxt_rdata = reg_read(sh_ff[5:2], main_ff, gdw_ff, ocm_ff, cfg_ff); // [R17]
    end
  end

  always_ff @(negedge I_SPI_SCLK or posedge frame_idle) begin
    if (frame_idle) begin
      cnt_ff <= 5'h00;
      sh_ff <= 15'h0000;
      rdata_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      rdata_ff <= nxt_rdata;
    end
  end

  // ========================================================================
  // Link side: word hand-off by toggles, kept across frames
  logic [15:0] word_ff, nxt_word;
  logic word_tgl_ff, nxt_word_tgl, over_tgl_ff, nxt_over_tgl;

  always_comb begin
    nxt_word = word_ff;
    nxt_word_tgl = word_tgl_ff;
    nxt_over_tgl = over_tgl_ff;
    if (cnt_ff == `WORD_LAST_EDGE) begin
      nxt_word = {sh_ff, I_SPI_SDI};
      nxt_word_tgl = ~word_tgl_ff;
    end
    if (cnt_ff == `WORD_OVER_EDGE) begin
      nxt_over_tgl = ~over_tgl_ff;
    end
  end

  always_ff @(negedge I_SPI_SCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      word_ff <= 16'h0000;
      word_tgl_ff <= 1'b0;
      over_tgl_ff <= 1'b0;
    end else begin
      word_ff <= nxt_word;
      word_tgl_ff <= nxt_word_tgl;
      over_tgl_ff <= nxt_over_tgl;
    end
  end

  // ========================================================================
  // Link side: serial out on the rising edge, data byte in the second half
  logic sdo_ff, nxt_sdo;
  logic [2:0] sdo_idx;

  always_comb begin
    sdo_idx = 3'(5'h0f - cnt_ff);
    nxt_sdo = 1'b0;
    if (cnt_ff >= `WORD_DATA_FIRST && cnt_ff <= `WORD_LAST_EDGE) begin
      nxt_sdo = rdata_ff[sdo_idx];
    end
  end

  always_ff @(posedge I_SPI_SCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sdo_ff <= 1'b0;
    end else begin
      sdo_ff <= nxt_sdo;
    end
  end

  assign O_SPI_SDO = sdo_ff;

  // ========================================================================
  // System side: synchronisers {cs, word toggle, over toggle, pin1, pin2}
  logic [4:0] sync_meta_ff, sync_ff, nxt_sync_meta, nxt_sync;

  always_comb begin
    nxt_sync_meta = {I_SPI_CS_N, word_tgl_ff, over_tgl_ff, I_BRIDGE_INPUT_FIRST,
                     I_BRIDGE_INPUT_SECOND};
    nxt_sync = sync_meta_ff;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sync_meta_ff <= 5'h10;
      sync_ff <= 5'h10;
    end else begin
      sync_meta_ff <= nxt_sync_meta;
      sync_ff <= nxt_sync;
    end
  end

  // ========================================================================
  // System side: frame end detection; a word counts only with exactly 16 edges
  logic cs_last_ff, word_ack_ff, over_ack_ff;
  logic nxt_cs_last, nxt_word_ack, nxt_over_ack;
  logic frame_end, frame_ok, wr_en;
  reg_addr_type wr_addr;
  reg_byte_type wr_data;

  // The word is stable here: SCLK has stopped for at least two system cycles
  always_comb begin
    frame_end = sync_ff[4] & ~cs_last_ff;
    frame_ok = frame_end & (sync_ff[3] ^ word_ack_ff) & ~(sync_ff[2] ^ over_ack_ff);
    wr_en = frame_ok & ~word_ff[`WORD_READ_BIT]; // [R18]
    wr_addr = word_ff[`WORD_ADDR_MSB:`WORD_ADDR_LSB]; // [R18]
    wr_data = word_ff[7:0];
    nxt_cs_last = sync_ff[4];
    nxt_word_ack = frame_end ? sync_ff[3] : word_ack_ff;
    nxt_over_ack = frame_end ? sync_ff[2] : over_ack_ff;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cs_last_ff <= 1'b1;
      word_ack_ff <= 1'b0;
      over_ack_ff <= 1'b0;
    end else begin
      cs_last_ff <= nxt_cs_last;
      word_ack_ff <= nxt_word_ack;
      over_ack_ff <= nxt_over_ack;
    end
  end

  // ========================================================================
  // Register bank and lock state
  reg_byte_type nxt_main, nxt_gdw, nxt_ocm, nxt_cfg;
  lock_state_type nxt_lock;
  logic [2:0] wr_key;

  always_comb begin
    nxt_main = main_ff;
    nxt_gdw = gdw_ff;
    nxt_ocm = ocm_ff;
    nxt_cfg = cfg_ff;
    nxt_lock = lock_ff;
    wr_key = wr_data[`LOCK_MSB:`LOCK_LSB];
    nxt_main[`FAULT_CLEAR_BIT] = 1'b0; // [R8]
    if (wr_en && wr_addr == `MAIN_CONTROL_OFS) begin
      nxt_main = wr_data; // [R7] [R17]
      unique case (lock_ff)
        LOCK_OPEN: begin
          if (wr_key == `LOCK_KEY) begin
            nxt_lock = LOCK_SHUT; // [R1] [R2]
          end
        end
        LOCK_SHUT: begin
          if (wr_key == `UNLOCK_KEY) begin
            nxt_lock = LOCK_OPEN; // [R3] [R4]
          end
        end
      endcase
    end else if (wr_en && lock_ff == LOCK_OPEN) begin // [R1]
      if (wr_addr == `GATE_WD_CONTROL_OFS) begin
        nxt_gdw = wr_data; // [R9] [R11] [R12]
      end
      if (wr_addr == `OVERCURRENT_CONTROL_OFS) begin
        nxt_ocm = wr_data; // [R13] [R14] [R15]
      end
      if (wr_addr == `CONFIG_CONTROL_OFS) begin
        nxt_cfg = wr_data; // [R17]
      end
    end
    // Lock field always shows the key of the current state
    nxt_main[`LOCK_MSB:`LOCK_LSB] = (nxt_lock == LOCK_SHUT) ? `LOCK_KEY : `UNLOCK_KEY;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      main_ff <= `MAIN_CONTROL_RST; // [R3]
      gdw_ff <= `GATE_WD_CONTROL_RST; // [R9] [R10] [R12]
      ocm_ff <= `OVERCURRENT_CONTROL_RST; // [R13] [R14] [R15]
      cfg_ff <= `CONFIG_CONTROL_RST;
      lock_ff <= LOCK_OPEN;
    end else begin
      main_ff <= nxt_main;
      gdw_ff <= nxt_gdw;
      ocm_ff <= nxt_ocm;
      cfg_ff <= nxt_cfg;
      lock_ff <= nxt_lock;
    end
  end

  // ========================================================================
  // Watchdog and registered outputs
  wd_count_type wd_cnt_ff, nxt_wd_cnt;
  logic wd_exp_ff, nxt_wd_exp, br1_ff, br2_ff, nxt_br1, nxt_br2, oe_ff, nxt_oe;
  logic [7:0] dead_ff, nxt_dead;
  logic br1_src, br2_src;

  // Any good frame restarts the watchdog, as a sign of a live host
  always_comb begin
    nxt_wd_cnt = wd_cnt_ff + 25'h0000001;
    nxt_wd_exp = 1'b0;
    if (!gdw_ff[`WD_ENABLE_BIT] || frame_ok) begin
      nxt_wd_cnt = 25'h0000000; // [R10]
    end else if (wd_cnt_ff >= wd_limit(gdw_ff[`WD_SEL_MSB:`WD_SEL_LSB]) - 25'h0000001) begin
      nxt_wd_cnt = 25'h0000000; // [R11]
      nxt_wd_exp = 1'b1;
    end
    br1_src = main_ff[`BRIDGE_FIRST_BIT] | sync_ff[1];
    br2_src = main_ff[`BRIDGE_SECOND_BIT] | sync_ff[0];
    nxt_br1 = br1_src; // [R5]
    nxt_br2 = br2_src; // [R6]
    nxt_dead = dead_cycles(gdw_ff[`DEAD_TIME_MSB:`DEAD_TIME_LSB]); // [R9]
    nxt_oe = ~sync_ff[4];
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wd_cnt_ff <= 25'h0000000;
      wd_exp_ff <= 1'b0;
      br1_ff <= 1'b0;
      br2_ff <= 1'b0;
      dead_ff <= 8'h00;
      oe_ff <= 1'b0;
    end else begin
      wd_cnt_ff <= nxt_wd_cnt;
      wd_exp_ff <= nxt_wd_exp;
      br1_ff <= nxt_br1;
      br2_ff <= nxt_br2;
      dead_ff <= nxt_dead;
      oe_ff <= nxt_oe;
    end
  end

  assign O_SPI_SDO_OE = oe_ff;
  assign O_BRIDGE_INPUT_FIRST = br1_ff;
  assign O_BRIDGE_INPUT_SECOND = br2_ff;
  assign O_FAULT_CLEAR = main_ff[`FAULT_CLEAR_BIT];
  assign O_LOCKED = lock_ff[1];
  assign O_DEAD_TIME_SELECT = gdw_ff[`DEAD_TIME_MSB:`DEAD_TIME_LSB];
  assign O_DEAD_TIME_CYCLES = dead_ff;
  assign O_WATCHDOG_ENABLE = gdw_ff[`WD_ENABLE_BIT];
  assign O_WATCHDOG_TIMEOUT_SELECT = gdw_ff[`WD_SEL_MSB:`WD_SEL_LSB];
  assign O_WATCHDOG_EXPIRED = wd_exp_ff;
  assign O_GATE_CURRENT_CODE = gdw_ff[`GATE_CODE_MSB:`GATE_CODE_LSB];
  assign O_AMP_OUTPUT_LIMIT = ocm_ff[`AMP_LIMIT_BIT];
  assign O_OVERCURRENT_THRESHOLD_CODE = ocm_ff[`OC_THR_MSB:`OC_THR_LSB];
  assign O_BRIDGE2_HIGH_MONITOR_OFF = ocm_ff[`B2_HIGH_OFF_BIT];
  assign O_BRIDGE2_LOW_MONITOR_OFF = ocm_ff[`B2_LOW_OFF_BIT];
  assign O_BRIDGE1_HIGH_MONITOR_OFF = ocm_ff[`B1_HIGH_OFF_BIT];
  assign O_BRIDGE1_LOW_MONITOR_OFF = ocm_ff[`B1_LOW_OFF_BIT];
  assign O_CONFIGURATION_CONTROL = cfg_ff;

  // ========================================================================
  // Assertions
  default clocking sys_cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RSTN);

  logic wr_main;
  assign wr_main = wr_en && wr_addr == `MAIN_CONTROL_OFS;

  lock_enter_a: assert property ( // [R1]
    wr_main && lock_ff == LOCK_OPEN && wr_key == `LOCK_KEY |=> O_LOCKED)
    else $error("lock key did not lock");
  locked_ignore_a: assert property ( // [R1]
    wr_en && lock_ff == LOCK_SHUT && wr_addr != `MAIN_CONTROL_OFS
      |=> $stable(gdw_ff) && $stable(ocm_ff) && $stable(cfg_ff))
    else $error("write accepted while locked");
  bad_key_open_a: assert property ( // [R2]
    wr_main && lock_ff == LOCK_OPEN && wr_key != `LOCK_KEY |=> !O_LOCKED)
    else $error("wrong key changed unlocked state");
  unlock_a: assert property ( // [R3]
    wr_main && wr_key == `UNLOCK_KEY |=> !O_LOCKED && main_ff[5:3] == `UNLOCK_KEY)
    else $error("unlock key did not unlock");
  bad_key_shut_a: assert property ( // [R4]
    wr_main && lock_ff == LOCK_SHUT && wr_key != `UNLOCK_KEY |=> O_LOCKED)
    else $error("wrong key released lock");
  bridge_first_a: assert property ( // [R5]
    O_BRIDGE_INPUT_FIRST == $past(br1_src))
    else $error("first bridge input not OR of bit and pin");
  bridge_second_a: assert property ( // [R6]
    O_BRIDGE_INPUT_SECOND == $past(br2_src))
    else $error("second bridge input not OR of bit and pin");
  fault_pulse_a: assert property ( // [R7]
    wr_main && wr_data[`FAULT_CLEAR_BIT] |=> O_FAULT_CLEAR)
    else $error("fault clear not issued");
  fault_selfclear_a: assert property ( // [R8]
    O_FAULT_CLEAR |=> !O_FAULT_CLEAR)
    else $error("fault clear bit stuck");
  dead_cycles_a: assert property ( // [R9]
    $changed(O_DEAD_TIME_SELECT) |=> O_DEAD_TIME_CYCLES == dead_cycles(O_DEAD_TIME_SELECT))
    else $error("dead time count wrong");
  wd_idle_a: assert property ( // [R10]
    !O_WATCHDOG_ENABLE |=> wd_cnt_ff == 25'h0000000 && !O_WATCHDOG_EXPIRED)
    else $error("watchdog ran while disabled");
  wd_timeout_a: assert property ( // [R11]
    O_WATCHDOG_EXPIRED |-> $past(wd_cnt_ff) == wd_limit(O_WATCHDOG_TIMEOUT_SELECT) - 25'h0000001)
    else $error("watchdog expired at wrong count");
  oc_write_a: assert property ( // [R14]
    wr_en && !O_LOCKED && wr_addr == `OVERCURRENT_CONTROL_OFS
      |=> {O_AMP_OUTPUT_LIMIT, O_OVERCURRENT_THRESHOLD_CODE} == ocm_ff[7:4] && ocm_ff == $past(wr_data))
    else $error("overcurrent register write lost");

  lock_enter_c: cover property (wr_main && lock_ff == LOCK_OPEN && wr_key == `LOCK_KEY);
  fault_clear_c: cover property (O_FAULT_CLEAR);
  wd_expire_c: cover property (O_WATCHDOG_EXPIRED);
  frame_error_c: cover property (frame_end && !frame_ok);

endmodule

// >>> verification/spi_host.sv
// Host-side serial controller model driving the control register bank
`timescale 1ns/1ps
module spi_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // ==========================================================================
  // One frame: the clock runs only while selected
  task automatic frame(input logic [15:0] w, input int nbits, output logic [7:0] q);
    int i;
    q = 8'h00;
    // Host writes only the control offsets
    if (!w[15] && (w[14:11] < 4'h2 || w[14:11] > 4'h5)) begin
      return;
    end
    o_cs_n = 1'b0;
    #15;
    for (i = 0; i < nbits; i++) begin
      o_sclk = 1'b1;
      o_sdi = w[15 - i];
      #7.5;
      o_sclk = 1'b0;
      q = {q[6:0], i_sdo};
      #7.5;
    end
    o_cs_n = 1'b1;
    // Released line shows the inverse of its last bit, never a stale copy
    o_sdi = ~o_sdi;
    #500;
  endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench of the H-bridge control register bank
`timescale 1ns/1ps
module tb;
  import hbridge_ctrl_pkg::*;
  localparam int LIMIT = 30000;
  localparam logic [2:0] KEYS [5] = '{3'h5, 3'h6, 3'h0, 3'h7, 3'h3};
  localparam logic [4:0] LKS = 5'h0e;
  localparam logic [7:0] LIMS [4] = '{8'h32, 8'h3c, 8'h46, 8'h50};
  logic I_SYS_CLK, I_RSTN;
  logic pin1 = 1'b0;
  logic pin2 = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe, b1, b2, fclr, locked, watchdog_enable_bit, wd_exp, amp;
  logic m3, m2, m1, m0;
  logic [1:0] dsel, wsel;
  logic [2:0] gate, thr;
  logic [7:0] dcyc, cfg, q;
  logic [7:0] sh [8] = '{8'h00, 8'h00, 8'h18, 8'h07, 8'h70, 8'h01, 8'h00, 8'h00};
  logic [31:0] seed = 32'hc3b52af1;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_clr = 0;
  int n_exp = 0;
  int n_oe = 0;
  int run = 0;
  int gap = 0;

  initial begin
    I_SYS_CLK = 1'b0;
    forever #2.5 I_SYS_CLK = ~I_SYS_CLK;
  end

  hbridge_driver_control_regs #(.WD_CYC_SEL0(25'h32), .WD_CYC_SEL1(25'h3c),
    .WD_CYC_SEL2(25'h46), .WD_CYC_SEL3(25'h50)) u_hbridge_driver_control_regs (
    .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_SPI_SCLK(sclk), .I_SPI_CS_N(cs_n),
    .I_SPI_SDI(sdi), .I_BRIDGE_INPUT_FIRST(pin1), .I_BRIDGE_INPUT_SECOND(pin2),
    .O_SPI_SDO(sdo), .O_SPI_SDO_OE(sdo_oe), .O_BRIDGE_INPUT_FIRST(b1),
    .O_BRIDGE_INPUT_SECOND(b2), .O_FAULT_CLEAR(fclr), .O_LOCKED(locked),
    .O_DEAD_TIME_SELECT(dsel), .O_DEAD_TIME_CYCLES(dcyc), .O_WATCHDOG_ENABLE(watchdog_enable_bit),
    .O_WATCHDOG_TIMEOUT_SELECT(wsel), .O_WATCHDOG_EXPIRED(wd_exp),
    .O_GATE_CURRENT_CODE(gate), .O_AMP_OUTPUT_LIMIT(amp),
    .O_OVERCURRENT_THRESHOLD_CODE(thr), .O_BRIDGE2_HIGH_MONITOR_OFF(m3),
    .O_BRIDGE2_LOW_MONITOR_OFF(m2), .O_BRIDGE1_HIGH_MONITOR_OFF(m1),
    .O_BRIDGE1_LOW_MONITOR_OFF(m0), .O_CONFIGURATION_CONTROL(cfg));

  spi_host u_spi_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] main_exp(input logic [7:0] v, input logic lk);
    return {v[7:6], lk ? 3'h6 : 3'h3, v[2:1], 1'b0};
  endfunction

  task automatic stop_test();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic rd, input logic [3:0] a, input logic [7:0] d, input int n);
    u_spi_host.frame({rd, a, 3'h0, d}, n, q);
    repeat (6) @(posedge I_SYS_CLK);
  endtask

  task automatic chk_outs();
    chk({dsel, watchdog_enable_bit, wsel, gate}, sh[3]);
    chk(dcyc, 8'h18 << sh[3][7:6]);
    chk({amp, thr, m3, m2, m1, m0}, sh[4]);
    chk(cfg, sh[5]);
  endtask

  // Sampled on the falling edge, where the registered outputs have settled
  always @(negedge I_SYS_CLK) begin
    cyc++;
    run++;
    if (fclr === 1'b1) n_clr++;
    if (sdo_oe === 1'b1) n_oe++;
    if (wd_exp === 1'b1) begin
      n_exp++;
      gap = run;
      run = 0;
    end
    if (cyc == LIMIT) begin
      n_errors++;
      stop_test();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [3:0] a;
    int i;
    I_RSTN = 1'b0;
    repeat (20) @(posedge I_SYS_CLK);
    I_RSTN <= 1'b1;
    repeat (4) @(posedge I_SYS_CLK);
    chk({7'h0, locked}, 8'h00);
    chk_outs();
    for (i = 2; i < 6; i++) begin
      xfer(1'b1, 4'(i), 8'h00, 16);
      chk(q, sh[i]);
    end
    // Random and boundary writes; a write returns the old contents
    for (i = 0; i < 9; i++) begin
      a = 4'(3 + i % 3);
      v = (i < 3) ? 8'hff : (i < 6) ? 8'h00 : 8'(rnd());
      xfer(1'b0, a, v, 16);
      chk(q, sh[a]);
      sh[a] = v;
      chk_outs();
      xfer(1'b1, a, 8'h00, 16);
      chk(q, v);
    end
    for (i = 0; i < 6; i++) begin
      v = 8'(rnd()) & 8'hc6 | 8'h18;
      @(posedge I_SYS_CLK);
      pin1 <= 1'(rnd());
      pin2 <= 1'(rnd());
      xfer(1'b0, 4'h2, v, 16);
      chk({6'h0, b1, b2}, {6'h0, v[2] | pin1, v[1] | pin2});
      xfer(1'b1, 4'h2, 8'h00, 16);
      chk(q, main_exp(v, 1'b0));
    end
    // Lock keys in order: other, lock, other, other, unlock
    for (i = 0; i < 5; i++) begin
      xfer(1'b0, 4'h2, {2'h0, KEYS[i], 3'h0}, 16);
      chk({7'h0, locked}, {7'h0, LKS[i]});
      v = 8'(rnd()) & 8'hdf;
      xfer(1'b0, 4'h3, v, 16);
      if (!LKS[i]) sh[3] = v;
      xfer(1'b1, 4'h3, 8'h00, 16);
      chk(q, sh[3]);
      xfer(1'b1, 4'h2, 8'h00, 16);
      chk(q, main_exp(8'h00, LKS[i]));
    end
    n_clr = 0;
    n_oe = 0;
    xfer(1'b0, 4'h2, 8'h19, 16);
    chk(8'(n_clr), 8'h01);
    // Output enable follows the 51-cycle select window, a few cycles late
    chk(8'(n_oe >= 48 && n_oe <= 53), 8'h01);
    chk({7'h0, sdo_oe}, 8'h00);
    xfer(1'b1, 4'h2, 8'h00, 16);
    chk(q, 8'h18);
    // Short frame is dropped; reserved offsets read zero
    xfer(1'b0, 4'h3, ~sh[3], 15);
    xfer(1'b1, 4'h3, 8'h00, 16);
    chk(q, sh[3]);
    xfer(1'b1, 4'h7, 8'h00, 16);
    chk(q, 8'h00);
    xfer(1'b1, 4'h0, 8'h00, 16);
    chk(q, 8'h00);
    for (i = 0; i < 4; i++) begin
      sh[3] = {2'(i), 1'b1, 2'(i), 3'h7};
      xfer(1'b0, 4'h3, sh[3], 16);
      n_exp = 0;
      repeat (400) begin
        if (n_exp < 3) @(posedge I_SYS_CLK);
      end
      chk(8'(gap == LIMS[i] || gap == LIMS[i] + 1), 8'h01);
      chk_outs();
    end
    sh[3] = 8'h07;
    xfer(1'b0, 4'h3, sh[3], 16);
    n_exp = 0;
    repeat (200) @(posedge I_SYS_CLK);
    chk(8'(n_exp), 8'h00);
    stop_test();
  end
endmodule
